// File: ecs_array.v
// Word-wide EEPROM storage with two read ports and one write port
`timescale 1ns/10ps
`include "ecs_defines.vh"

module ecs_array #(
  parameter AW = `ECS_WORD_AW,
  parameter DW = `ECS_DATA_W
) (
  // Clock
  input  wire          clk_i,
  // Write port
  input  wire          we_i,
  input  wire [AW-1:0] waddr_i,
  input  wire [DW-1:0] wdata_i,
  // Bus read port
  input  wire [AW-1:0] raddr_a_i,
  output wire [DW-1:0] rdata_a_o,
  // Scan read port
  input  wire [AW-1:0] raddr_b_i,
  output wire [DW-1:0] rdata_b_o
);

  reg [DW-1:0] mem [0:(1<<AW)-1];

  // Storage update
  always @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  // Unregistered reads, the caller registers them
  assign rdata_a_o = mem[raddr_a_i];
  assign rdata_b_o = mem[raddr_b_i];

endmodule // ecs_array

// File: ecs_defines.vh
// Shared constants for the EEPROM command sequencer
`ifndef ECS_DEFINES_VH
`define ECS_DEFINES_VH

// ----------------------------------------------------------------
// Bus and array geometry
// ----------------------------------------------------------------
`define ECS_ADDR_W        23
`define ECS_DATA_W        16
`define ECS_WORD_AW       11
`define ECS_ARRAY_PAGE    11'h13f
`define ECS_LAST_WORD     11'h7ff
`define ECS_ERASED_WORD   16'hffff

// ----------------------------------------------------------------
// Register addresses (global)
// ----------------------------------------------------------------
`define ECS_STAT_ADDR     23'h000110
`define ECS_CMD_ADDR      23'h000111
`define ECS_PROT_ADDR     23'h000112
`define ECS_ABUF_ADDR     23'h000113
`define ECS_DBUF_ADDR     23'h000114

// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define ECS_ST_BUFFER_EMPTY_FLAG      7
`define ECS_ST_COMMAND_COMPLETE_FLAG       6
`define ECS_ST_PROTECTION_VIOLATION_FLAG      5
`define ECS_ST_ACCESS_ERROR_FLAG     4
`define ECS_ST_BLANK      2

// ----------------------------------------------------------------
// Protection register fields
// ----------------------------------------------------------------
`define ECS_PROT_EN       7
`define ECS_PROT_SZ_HI    2
`define ECS_PROT_SZ_LO    0
`define ECS_PROT_TOP      12'hfc0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define ECS_PROT_RST      8'h00
`define ECS_CMD_RST       8'h00

// ----------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------
`define ECS_CMD_VERIFY    8'h05
`define ECS_CMD_PROG      8'h20
`define ECS_CMD_ERASE     8'h40
`define ECS_CMD_ABORT     8'h60

// ----------------------------------------------------------------
// Timing counts in bus cycles
// ----------------------------------------------------------------
`define ECS_LAUNCH_DLY    3'h4
`define ECS_PROG_CYCLES   16'h0010
`define ECS_ERASE_CYCLES  16'h0020
`define ECS_ABORT_CYCLES  16'h0008

`endif

// File: ecs_host_model.sv
// Processor-side bus master model for the command sequencer
`timescale 1ns/10ps
`include "ecs_defines.vh"

module ecs_host_model (
  // Clock
  input  wire         clk_i,
  // Bus towards the sequencer
  output logic [22:0] addr_o,
  output logic [15:0] wdata_o,
  output logic        wr_o,
  output logic        rd_o,
  input  wire  [15:0] rdata_i
);
  // Quiet bus from time zero
  initial begin
    addr_o  = 23'h000000;
    wdata_o = 16'h0000;
    wr_o    = 1'b0;
    rd_o    = 1'b0;
  end

  // One write, taken at the next edge
  task automatic wr(input logic [22:0] a, input logic [15:0] d);
    addr_o  <= a;
    wdata_o <= d;
    wr_o    <= 1'b1;
    rd_o    <= 1'b0;
    @(posedge clk_i);
  endtask

  // One read; answer stands only in the following cycle
  task automatic rd(input logic [22:0] a, output logic [15:0] d);
    addr_o  <= a;
    wdata_o <= ~wdata_o;
    wr_o    <= 1'b0;
    rd_o    <= 1'b1;
    @(posedge clk_i);
    #1 d = rdata_i;
  endtask

  // Idle bus, released lines toggled so stale values never match
  task automatic idle(input int n);
    wr_o    <= 1'b0;
    rd_o    <= 1'b0;
    addr_o  <= ~addr_o;
    wdata_o <= ~wdata_o;
    repeat (n) @(posedge clk_i);
  endtask

  // Three steps strictly in order with no write between them
  task automatic seq(input logic [22:0] a, input logic [15:0] d,
                     input logic [7:0] c);
    wr(a, d);
    wr(`ECS_CMD_ADDR, {8'h00, c});
    wr(`ECS_STAT_ADDR, 16'h0080);
  endtask
endmodule // ecs_host_model

// File: ecs_sequencer.v
// EEPROM command sequencer: sequence checks, flags and array engine
`timescale 1ns/10ps
`include "ecs_defines.vh"

module ecs_sequencer #(
  parameter [15:0] PROG_CYCLES  = `ECS_PROG_CYCLES,
  parameter [15:0] ERASE_CYCLES = `ECS_ERASE_CYCLES,
  parameter [15:0] ABORT_CYCLES = `ECS_ABORT_CYCLES
) (
  // Clock and reset
  input  wire        clk_i,
  input  wire        rst_n_i,
  // Register and array port
  input  wire [22:0] addr_i,
  input  wire [15:0] wdata_i,
  input  wire        wr_i,
  input  wire        rd_i,
  output wire [15:0] rdata_o
);

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam [2:0] S_IDLE  = 3'b001;
  localparam [2:0] S_ADDR  = 3'b010;
  localparam [2:0] S_CMD   = 3'b100;
  localparam [3:0] E_IDLE  = 4'b0001;
  localparam [3:0] E_WAIT  = 4'b0010;
  localparam [3:0] E_WRITE = 4'b0100;
  localparam [3:0] E_SCAN  = 4'b1000;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg  [2:0]  seq_ff;
  reg  [11:0] buf_addr_ff;
  reg  [15:0] buf_data_ff;
  reg  [7:0]  buf_cmd_ff;
  reg         pend_ff;
  reg         buffer_empty_flag_ff;
  reg         command_complete_flag_ff;
  reg         protection_violation_flag_ff;
  reg         access_error_flag_ff;
  reg         blank_ff;
  reg  [7:0]  prot_ff;
  reg  [2:0]  dly_ff;
  reg         abort_ff;
  reg  [15:0] abort_cnt_ff;
  reg  [3:0]  est_ff;
  reg  [15:0] ecnt_ff;
  reg  [7:0]  act_cmd_ff;
  reg  [11:0] act_addr_ff;
  reg  [15:0] act_data_ff;
  reg  [10:0] scan_ff;
  reg         scan_ok_ff;
  reg  [15:0] rdata_ff;

  // Next values from the sequence checker
  reg  [2:0]  nxt_seq;
  reg  [11:0] nxt_buf_addr;
  reg  [15:0] nxt_buf_data;
  reg  [7:0]  nxt_buf_cmd;
  reg         start;
  reg         launch;
  reg         seq_err;
  reg         seq_protection_violation_flag;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  wire in_array = (addr_i[22:12] == `ECS_ARRAY_PAGE);
  wire arr_wr   = wr_i & in_array;
  wire st_wr    = wr_i & (addr_i == `ECS_STAT_ADDR);
  wire cmd_wr   = wr_i & (addr_i == `ECS_CMD_ADDR);
  wire prot_wr  = wr_i & (addr_i == `ECS_PROT_ADDR);
  wire go_wr    = st_wr & wdata_i[`ECS_ST_BUFFER_EMPTY_FLAG];

  // Command code check
  wire cmd_ok = (wdata_i[7:0] == `ECS_CMD_VERIFY) |
                (wdata_i[7:0] == `ECS_CMD_PROG) |
                (wdata_i[7:0] == `ECS_CMD_ERASE) |
                (wdata_i[7:0] == `ECS_CMD_ABORT);

  // Upper region guard
  wire [11:0] prot_lo  = `ECS_PROT_TOP -
                         {3'b000, prot_ff[`ECS_PROT_SZ_HI:`ECS_PROT_SZ_LO],
                          6'b000000};
  wire        modifies = (buf_cmd_ff == `ECS_CMD_PROG) |
                         (buf_cmd_ff == `ECS_CMD_ERASE);
  wire        guarded  = prot_ff[`ECS_PROT_EN] & modifies &
                         (buf_addr_ff >= prot_lo);

  // ----------------------------------------------------------------
  // Engine shared terms
  // ----------------------------------------------------------------
  wire abort_go  = launch & (buf_cmd_ff == `ECS_CMD_ABORT);
  wire act_erase = (act_cmd_ff == `ECS_CMD_ERASE);
  wire kill      = abort_go & (est_ff == E_WAIT) & act_erase;
  wire xfer      = pend_ff & (est_ff == E_IDLE) & ~abort_ff;
  wire drop      = start & pend_ff & ~xfer;
  wire wait_done = (est_ff == E_WAIT) & (ecnt_ff == 16'h0000);

  // Array write port
  wire        mem_we    = (wait_done & ~kill) | (est_ff == E_WRITE);
  wire [10:0] mem_waddr = (est_ff == E_WRITE) ?
                          {act_addr_ff[11:2], 1'b1} :
                          (act_erase ? {act_addr_ff[11:2], 1'b0} :
                           act_addr_ff[11:1]);
  wire [15:0] mem_wdata = act_erase ? `ECS_ERASED_WORD : act_data_ff;
  wire [15:0] bus_word;
  wire [15:0] scan_word;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  ecs_array #(
    .AW (`ECS_WORD_AW),
    .DW (`ECS_DATA_W)
  ) u_array (
    .clk_i     (clk_i),
    .we_i      (mem_we),
    .waddr_i   (mem_waddr),
    .wdata_i   (mem_wdata),
    .raddr_a_i (addr_i[11:1]),
    .rdata_a_o (bus_word),
    .raddr_b_i (scan_ff),
    .rdata_b_o (scan_word)
  );

  // ----------------------------------------------------------------
  // Command write sequence checker
  // ----------------------------------------------------------------
  // Three-step walk, any out-of-order write aborts the walk
  always @* begin
    nxt_seq      = seq_ff;
    nxt_buf_addr = buf_addr_ff;
    nxt_buf_data = buf_data_ff;
    nxt_buf_cmd  = buf_cmd_ff;
    start        = 1'b0;
    launch       = 1'b0;
    seq_err      = 1'b0;
    seq_protection_violation_flag    = 1'b0;
    case (seq_ff)
      S_IDLE: begin
        if (arr_wr && !abort_ff) begin
          nxt_buf_addr = addr_i[11:0];
          nxt_buf_data = wdata_i;
          nxt_seq      = S_ADDR;
          start        = 1'b1;
        end else if (arr_wr || cmd_wr || go_wr) begin
          seq_err      = 1'b1;
        end
      end
      S_ADDR: begin
        if (cmd_wr && cmd_ok) begin
          nxt_buf_cmd  = wdata_i[7:0];
          nxt_seq      = S_CMD;
        end else if (arr_wr || cmd_wr || go_wr || prot_wr) begin
          seq_err      = 1'b1;
          nxt_seq      = S_IDLE;
        end
      end
      S_CMD: begin
        if (go_wr && guarded) begin
          seq_protection_violation_flag    = 1'b1;
          nxt_seq      = S_IDLE;
        end else if (go_wr) begin
          launch       = 1'b1;
          nxt_seq      = S_IDLE;
        end else if (arr_wr || cmd_wr || prot_wr) begin
          seq_err      = 1'b1;
          nxt_seq      = S_IDLE;
        end
      end
      default: begin
        nxt_seq        = S_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Buffers, flags and protection
  // ----------------------------------------------------------------
  // Sequence buffers and the pending slot behind the active command
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      seq_ff      <= S_IDLE;
      buf_addr_ff <= 12'h000;
      buf_data_ff <= 16'h0000;
      buf_cmd_ff  <= `ECS_CMD_RST;
      pend_ff     <= 1'b0;
      prot_ff     <= `ECS_PROT_RST;
    end else begin
      seq_ff      <= nxt_seq;
      buf_addr_ff <= nxt_buf_addr;
      buf_data_ff <= nxt_buf_data;
      buf_cmd_ff  <= nxt_buf_cmd;
      if (launch && !abort_go) begin
        pend_ff   <= 1'b1;
      end else if (xfer || drop) begin
        pend_ff   <= 1'b0;
      end
      if (prot_wr && seq_ff == S_IDLE) begin
        prot_ff   <= wdata_i[7:0];
      end
    end
  end

  // Status flags, hardware set wins over software clear
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      buffer_empty_flag_ff  <= 1'b1;
      command_complete_flag_ff   <= 1'b1;
      protection_violation_flag_ff  <= 1'b0;
      access_error_flag_ff <= 1'b0;
      dly_ff    <= 3'h0;
    end else begin
      protection_violation_flag_ff  <= (protection_violation_flag_ff & ~(st_wr & wdata_i[`ECS_ST_PROTECTION_VIOLATION_FLAG])) |
                   seq_protection_violation_flag;
      access_error_flag_ff <= (access_error_flag_ff & ~(st_wr & wdata_i[`ECS_ST_ACCESS_ERROR_FLAG])) |
                   seq_err;
      if (launch) begin
        buffer_empty_flag_ff <= 1'b0;
        command_complete_flag_ff  <= 1'b0;
        dly_ff   <= abort_go ? 3'h0 : `ECS_LAUNCH_DLY;
      end else begin
        if (start && !buffer_empty_flag_ff) begin
          buffer_empty_flag_ff <= 1'b1;
          dly_ff   <= 3'h0;
        end else if (!buffer_empty_flag_ff && !pend_ff && dly_ff <= 3'h1 &&
                     !abort_ff) begin
          buffer_empty_flag_ff <= 1'b1;
        end
        if (dly_ff != 3'h0 && !(start && !buffer_empty_flag_ff)) begin
          dly_ff   <= dly_ff - 3'h1;
        end
        if (est_ff == E_IDLE && !pend_ff && !abort_ff && !xfer) begin
          command_complete_flag_ff  <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Sector erase abort timer
  // ----------------------------------------------------------------
  // Abort runs beside the engine and holds buffer-empty low
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      abort_ff     <= 1'b0;
      abort_cnt_ff <= 16'h0000;
    end else if (abort_go) begin
      abort_ff     <= 1'b1;
      abort_cnt_ff <= ABORT_CYCLES - 16'h0001;
    end else if (abort_ff) begin
      if (abort_cnt_ff == 16'h0000) begin
        abort_ff     <= 1'b0;
      end else begin
        abort_cnt_ff <= abort_cnt_ff - 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Array engine
  // ----------------------------------------------------------------
  // Runs one command at a time, takes the pending one when idle
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      est_ff      <= E_IDLE;
      ecnt_ff     <= 16'h0000;
      act_cmd_ff  <= `ECS_CMD_RST;
      act_addr_ff <= 12'h000;
      act_data_ff <= 16'h0000;
      scan_ff     <= 11'h000;
      scan_ok_ff  <= 1'b0;
      blank_ff    <= 1'b0;
    end else begin
      case (est_ff)
        E_IDLE: begin
          if (xfer) begin
            act_cmd_ff  <= buf_cmd_ff;
            act_addr_ff <= buf_addr_ff;
            act_data_ff <= buf_data_ff;
            if (buf_cmd_ff == `ECS_CMD_VERIFY) begin
              blank_ff   <= 1'b0;
              scan_ff    <= 11'h000;
              scan_ok_ff <= 1'b1;
              est_ff     <= E_SCAN;
            end else if (buf_cmd_ff == `ECS_CMD_ERASE) begin
              ecnt_ff    <= ERASE_CYCLES - 16'h0001;
              est_ff     <= E_WAIT;
            end else begin
              ecnt_ff    <= PROG_CYCLES - 16'h0001;
              est_ff     <= E_WAIT;
            end
          end
        end
        E_WAIT: begin
          if (kill) begin
            est_ff  <= E_IDLE;
          end else if (wait_done) begin
            // Program writes its word here, erase its first word
            est_ff  <= act_erase ? E_WRITE : E_IDLE;
          end else begin
            ecnt_ff <= ecnt_ff - 16'h0001;
          end
        end
        E_WRITE: begin
          est_ff <= E_IDLE;
        end
        E_SCAN: begin
          scan_ok_ff <= scan_ok_ff & (scan_word == `ECS_ERASED_WORD);
          if (scan_ff == `ECS_LAST_WORD) begin
            blank_ff <= scan_ok_ff &
                        (scan_word == `ECS_ERASED_WORD);
            est_ff   <= E_IDLE;
          end else begin
            scan_ff  <= scan_ff + 11'h001;
          end
        end
        default: begin
          est_ff <= E_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Read data valid only in the cycle after the read strobe
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      rdata_ff <= 16'h0000;
    end else if (!rd_i) begin
      rdata_ff <= 16'h0000;
    end else if (in_array) begin
      rdata_ff <= bus_word;
    end else begin
      case (addr_i)
        `ECS_STAT_ADDR: rdata_ff <= {8'h00, buffer_empty_flag_ff, command_complete_flag_ff, protection_violation_flag_ff,
                                     access_error_flag_ff, 1'b0, blank_ff, 2'b00};
        `ECS_CMD_ADDR:  rdata_ff <= {8'h00, buf_cmd_ff};
        `ECS_PROT_ADDR: rdata_ff <= {8'h00, prot_ff};
        `ECS_ABUF_ADDR: rdata_ff <= {4'h0, buf_addr_ff};
        `ECS_DBUF_ADDR: rdata_ff <= buf_data_ff;
        default:        rdata_ff <= 16'h0000;
      endcase
    end
  end

  assign rdata_o = rdata_ff;

endmodule // ecs_sequencer

// File: ecs_sequencer_props.sv
// Port-level assertions for the EEPROM command sequencer
`timescale 1ns/10ps
`include "ecs_defines.vh"

module ecs_sequencer_props (
  // Clock and reset
  input wire        clk_i,
  input wire        rst_n_i,
  // Register and array port
  input wire [22:0] addr_i,
  input wire [15:0] wdata_i,
  input wire        wr_i,
  input wire        rd_i,
  input wire [15:0] rdata_o
);
  // ----------------------------------------------------------------
  // Decoded bus events
  // ----------------------------------------------------------------
  wire arr_w = wr_i && (addr_i[22:12] == `ECS_ARRAY_PAGE);
  wire cmd_w = wr_i && (addr_i == `ECS_CMD_ADDR);
  wire go_w  = wr_i && (addr_i == `ECS_STAT_ADDR) && wdata_i[7];
  wire st_r  = rd_i && (addr_i == `ECS_STAT_ADDR);
  wire ab_r  = rd_i && (addr_i == `ECS_ABUF_ADDR);
  wire db_r  = rd_i && (addr_i == `ECS_DBUF_ADDR);
  wire cm_r  = rd_i && (addr_i == `ECS_CMD_ADDR);
  wire ok_c  = (wdata_i[7:0] == `ECS_CMD_VERIFY) ||
               (wdata_i[7:0] == `ECS_CMD_PROG) ||
               (wdata_i[7:0] == `ECS_CMD_ERASE) ||
               (wdata_i[7:0] == `ECS_CMD_ABORT);
  wire un_r  = rd_i && (addr_i[22:12] != `ECS_ARRAY_PAGE) &&
               ((addr_i < `ECS_STAT_ADDR) || (addr_i > `ECS_DBUF_ADDR));

  // Address and data two cycles back
  reg [22:0] addr_d1_ff;
  reg [22:0] addr_d2_ff;
  reg [15:0] data_d1_ff;
  reg [15:0] data_d2_ff;
  always @(posedge clk_i) begin
    addr_d1_ff <= addr_i;
    addr_d2_ff <= addr_d1_ff;
    data_d1_ff <= wdata_i;
    data_d2_ff <= data_d1_ff;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  // Three launch steps back to back
  sequence s_launch;
    arr_w ##1 (cmd_w && ok_c) ##1 go_w;
  endsequence

  a_read_quiet: assert property (!rd_i |=> rdata_o == 16'h0000)
    else $error("read data outside the answer cycle");
  a_unmapped_zero: assert property (un_r |=> rdata_o == 16'h0000)
    else $error("unmapped read returned data");
  a_command_complete_flag_order: assert property (st_r |=> rdata_o[7] || !rdata_o[6])
    else $error("complete flag set while buffers full");
  a_launch_clears: assert property (s_launch ##1 st_r |=>
    (!rdata_o[7] && !rdata_o[6]) || rdata_o[5])
    else $error("launch left a flag set");
  a_launch_hold: assert property (s_launch ##1 (!wr_i)[*2] ##1 st_r |=>
    !rdata_o[7] || rdata_o[5])
    else $error("buffer flag set too early");
  a_abuf_capture: assert property (arr_w ##1 ab_r |=>
    rdata_o[11:0] == addr_d2_ff[11:0])
    else $error("address buffer missed array write");
  a_dbuf_capture: assert property (arr_w ##1 db_r |=>
    rdata_o == data_d2_ff)
    else $error("data buffer missed array write");
  a_cmd_capture: assert property ((cmd_w && ok_c) ##1 cm_r |=>
    rdata_o[7:0] == data_d2_ff[7:0])
    else $error("command buffer missed write");
  a_double_write: assert property (arr_w ##1 arr_w ##1 st_r |=>
    rdata_o[4])
    else $error("second array write not flagged");
  a_bad_code: assert property (arr_w ##1 (cmd_w && !ok_c) ##1 st_r |=>
    rdata_o[4])
    else $error("invalid code not flagged");

  // Main scenarios reached
  c_launch: cover property (s_launch);
  c_double: cover property (arr_w ##1 arr_w);
  c_unmapped: cover property (un_r);
endmodule // ecs_sequencer_props

bind ecs_sequencer ecs_sequencer_props u_props (
  .clk_i   (clk_i),
  .rst_n_i (rst_n_i),
  .addr_i  (addr_i),
  .wdata_i (wdata_i),
  .wr_i    (wr_i),
  .rd_i    (rd_i),
  .rdata_o (rdata_o)
);

// File: ecs_sequencer_tb.sv
// Self-checking bench for the EEPROM command sequencer
`timescale 1ns/10ps
`include "ecs_defines.vh"

module ecs_sequencer_tb;
  logic        clk_i;
  logic        rst_n_i;
  wire  [22:0] addr;
  wire  [15:0] wdata;
  wire         wr;
  wire         rd;
  wire  [15:0] rdata;
  logic [15:0] d;
  int          err_count;
  int          total_checks;
  // Rows: address read after reset beside the value expected
  logic [22:0] row_a [6] = '{`ECS_STAT_ADDR, `ECS_CMD_ADDR,
    `ECS_PROT_ADDR, 23'h000115, 23'h13e000, 23'h140000};
  logic [15:0] row_e [6] = '{16'h00c0, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000};

  ecs_sequencer #(
    .PROG_CYCLES  (16'h0002),
    .ABORT_CYCLES (16'h0002)
  ) dut (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .addr_i  (addr),
    .wdata_i (wdata),
    .wr_i    (wr),
    .rd_i    (rd),
    .rdata_o (rdata)
  );

  ecs_host_model host (
    .clk_i   (clk_i),
    .addr_o  (addr),
    .wdata_o (wdata),
    .wr_o    (wr),
    .rd_o    (rd),
    .rdata_i (rdata)
  );

  // 25 MHz bus clock
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  // ----------------------------------------------------------------
  // Check and report helpers
  // ----------------------------------------------------------------
  task automatic chk(input string n, input logic [15:0] s,
                     input logic [15:0] e);
    total_checks++;
    if (s !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic rchk(input string n, input logic [22:0] a,
                      input logic [15:0] e);
    host.rd(a, d);
    chk(n, d, e);
  endtask

  task automatic sbit(input int b, input logic e);
    host.rd(`ECS_STAT_ADDR, d);
    chk("status bit", {15'h0000, d[b]}, {15'h0000, e});
  endtask

  // Poll a status bit until set, bounded
  task automatic wait_flag(input int b);
    int i;
    for (i = 0; i < 3000; i++) begin
      host.rd(`ECS_STAT_ADDR, d);
      if (d[b] === 1'b1)
        return;
    end
    err_count++;
    $display("[FAIL] status bit %0d expected 1 seen 0", b);
    summarize();
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    err_count = 0;
    total_checks = 0;
    rst_n_i = 1'b0;
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    for (int k = 0; k < 6; k++) begin
      rchk("reset row", row_a[k], row_e[k]);
    end
    // Program with buffer readback and exact flag timing
    host.wr(23'h13f020, 16'h1234);
    rchk("data buffer", `ECS_DBUF_ADDR, 16'h1234);
    host.wr(`ECS_CMD_ADDR, 16'h0020);
    rchk("command", `ECS_CMD_ADDR, 16'h0020);
    host.wr(`ECS_STAT_ADDR, 16'h0080);
    host.rd(`ECS_STAT_ADDR, d);
    chk("launch flags", {8'h00, d[7:6], 6'h00}, 16'h0000);
    host.idle(1);
    sbit(7, 1'b0);
    host.idle(1);
    sbit(7, 1'b1);
    wait_flag(6);
    rchk("word", 23'h13f020, 16'h1234);
    // Erase, buffered program, then overwrite of the pending one
    host.seq(23'h13f011, 16'h0000, `ECS_CMD_ERASE);
    wait_flag(7);
    host.seq(23'h13f020, 16'habcd, `ECS_CMD_PROG);
    host.wr(23'h13f024, 16'h1111);
    rchk("addr buffer", `ECS_ABUF_ADDR, 16'h0024);
    sbit(7, 1'b1);
    host.wr(`ECS_CMD_ADDR, 16'h0020);
    host.wr(`ECS_STAT_ADDR, 16'h0080);
    sbit(6, 1'b0);
    host.idle(6);
    sbit(7, 1'b0);
    wait_flag(6);
    rchk("erased lo", 23'h13f010, 16'hffff);
    rchk("erased hi", 23'h13f012, 16'hffff);
    rchk("dropped", 23'h13f020, 16'h1234);
    rchk("buffered", 23'h13f024, 16'h1111);
    // Abort of a waiting sector erase
    host.seq(23'h13f030, 16'h5555, `ECS_CMD_PROG);
    wait_flag(6);
    host.seq(23'h13f030, 16'h0000, `ECS_CMD_ERASE);
    wait_flag(7);
    host.seq(23'h13f030, 16'h0000, `ECS_CMD_ABORT);
    sbit(7, 1'b0);
    wait_flag(6);
    rchk("aborted", 23'h13f030, 16'h5555);
    // Extra array write, then invalid code
    for (int k = 0; k < 2; k++) begin
      host.wr(23'h13f040, 16'h0001);
      host.wr(k ? `ECS_CMD_ADDR : 23'h13f042, 16'h0033);
      sbit(4, 1'b1);
      host.wr(`ECS_STAT_ADDR, 16'h0010);
      sbit(4, 1'b0);
    end
    // Protected top region refuses a program
    host.wr(`ECS_PROT_ADDR, 16'h0080);
    rchk("prot on", `ECS_PROT_ADDR, 16'h0080);
    host.seq(23'h13ffc0, 16'h7777, `ECS_CMD_PROG);
    host.rd(`ECS_STAT_ADDR, d);
    chk("refused", {8'h00, d[7:5], 5'h00}, 16'h00e0);
    host.wr(`ECS_STAT_ADDR, 16'h0020);
    host.wr(`ECS_PROT_ADDR, 16'h0000);
    rchk("prot off", `ECS_PROT_ADDR, 16'h0000);
    // Mid-run reset over a launched program and armed protection
    host.wr(`ECS_PROT_ADDR, 16'h0081);
    host.seq(23'h13f200, 16'h2222, `ECS_CMD_PROG);
    rst_n_i <= 1'b0;
    host.idle(2);
    rst_n_i <= 1'b1;
    host.idle(1);
    rchk("reset status", `ECS_STAT_ADDR, 16'h00c0);
    rchk("reset prot", `ECS_PROT_ADDR, 16'h0000);
    // Erase every sector, then blank check both ways
    for (int s = 0; s < 1024; s++) begin
      host.seq(23'h13f000 + 23'(4 * s), 16'h0000, `ECS_CMD_ERASE);
      wait_flag(6);
    end
    for (int k = 0; k < 2; k++) begin
      host.seq(23'h13f000, 16'h0000, `ECS_CMD_VERIFY);
      wait_flag(6);
      sbit(2, k == 0);
      host.seq(23'h13f100, 16'h0001, `ECS_CMD_PROG);
      wait_flag(6);
    end
    summarize();
  end
endmodule // ecs_sequencer_tb
